// ==== src/sef_top.sv ====
// Servo enable gating and the positioning-done / speed-match flags.
// Assumes an AHB-Lite master on i_ref_clk and a control loop that
// presents its errors with a one-cycle update strobe.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module sef_top
    import sef_pkg::*;
(
    // Clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_sys_rst,
    // AHB-Lite slave
    input  wire logic               i_hsel,
    input  wire logic [31:0]        i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    output logic      [31:0]        o_hrdata,
    output logic                    o_hreadyout,
    output logic                    o_hresp,
    // Sequence pin and control loop
    input  wire logic               i_servo_enable_n,
    input  wire logic               i_loop_update,
    input  wire sef_loop_type       i_loop,
    // Outputs
    output logic                    o_servo_on,
    output logic                    o_positioning_done_output_n,
    output logic                    o_speed_match_output_n,
    output logic                    o_flag_terminal_n,
    output logic                    o_irq
);
    // ********************************
    // Registers
    // ********************************
    logic [3:0]              map_q;
    sef_mode_type            mode_q;
    logic [SEF_WIDTH_W-1:0]  pos_width_q;
    logic [SEF_WIDTH_W-1:0]  spd_width_q;
    logic [SEF_ALLOC_W-1:0]  alloc_q;
    logic [SEF_NUM_EV-1:0]   irq_stat_q;
    logic [SEF_NUM_EV-1:0]   irq_mask_q;
    logic                    pos_below_q;
    logic                    spd_below_q;
    logic                    servo_on_q;
    logic                    pos_done_n_q;
    logic                    spd_match_n_q;
    logic                    flag_n_q;
    logic                    wr_pend_q;
    logic [7:0]              wr_addr_q;
    logic [31:0]             rdata_q;

    // ********************************
    // Pin input and comparators
    // ********************************
    logic enable_n_sync;
    logic pos_below;
    logic spd_below;

    sef_sync u_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_servo_enable_n),
        .i_rst_val (1'b1),
        .o_level   (enable_n_sync)
    );

    // Width feeds only these compares, never the loop itself
    sef_cmp u_pos_cmp
    (
        .i_a     (i_loop.pos_err),
        .i_b     ({SEF_ERR_W{1'b0}}),
        .i_width (pos_width_q),
        .o_below (pos_below)
    );

    sef_cmp u_spd_cmp
    (
        .i_a     (i_loop.spd_ref),
        .i_b     (i_loop.spd_act),
        .i_width (spd_width_q),
        .o_below (spd_below)
    );

    // ********************************
    // Bus decode
    // ********************************
    wire        addr_phase = i_hsel & i_hready & i_htrans[1];
    wire        wr_start   = addr_phase & i_hwrite;
    wire        rd_start   = addr_phase & ~i_hwrite;
    wire [7:0]  rd_ofs     = i_haddr[7:0];
    wire        in_range   = (i_haddr[31:8] == 24'h0000_00);
    wire        do_wr      = wr_pend_q;
    wire        wr_ctrl    = do_wr & (wr_addr_q == SEF_OFS_CTRL);
    wire        wr_posw    = do_wr & (wr_addr_q == SEF_OFS_POS_WIDTH);
    wire        wr_spdw    = do_wr & (wr_addr_q == SEF_OFS_SPD_WIDTH);
    wire        wr_alloc   = do_wr & (wr_addr_q == SEF_OFS_OUT_ALLOC);
    wire        wr_istat   = do_wr & (wr_addr_q == SEF_OFS_IRQ_STAT);
    wire        wr_imask   = do_wr & (wr_addr_q == SEF_OFS_IRQ_MASK);
    wire [7:0]  wdata_w    = i_hwdata[SEF_WIDTH_W-1:0];
    wire [1:0]  wmode      = i_hwdata[SEF_CTRL_MODE_LSB +: SEF_CTRL_MODE_W];

    // Out-of-range widths saturate to the top of the range
    wire [7:0]  posw_d = (wdata_w > SEF_POS_WIDTH_MAX) ?
                         SEF_POS_WIDTH_MAX : wdata_w;
    wire [7:0]  spdw_d = (wdata_w > SEF_SPD_WIDTH_MAX) ?
                         SEF_SPD_WIDTH_MAX : wdata_w;
    // Only the two documented mapping codes are accepted
    wire [3:0]  wmap   = i_hwdata[SEF_CTRL_MAP_LSB +: SEF_CTRL_MAP_W];
    wire        map_ok = (wmap == SEF_MAP_GATED) ||
                         (wmap == SEF_MAP_ALWAYS_ON);
    // Code 2'b11 names no mode; such writes keep the old mode
    wire        mode_ok = (wmode != 2'b11);

    // ********************************
    // Servo enable and flags
    // ********************************
    wire servo_on_d  = (map_q == SEF_MAP_ALWAYS_ON) ? 1'b1
                     : ~enable_n_sync;
    wire pos_mode    = (mode_q == SEF_MODE_POSITION);
    wire spd_mode    = (mode_q == SEF_MODE_SPEED);
    wire trq_mode    = (mode_q == SEF_MODE_TORQUE);
    wire pos_done_d  = pos_mode & pos_below_q;
    wire spd_match_d = spd_mode & spd_below_q;
    // Shared pair routed only while allocation nibble selects it
    wire alloc_on    = (alloc_q[3:0] == SEF_ALLOC_FLAG_ON);
    wire flag_d      = alloc_on & (pos_done_d | spd_match_d
                                   | trq_mode);

    // Events: rising edges of enabled, done and match
    wire [SEF_NUM_EV-1:0] ev_now = {spd_match_d, pos_done_d, servo_on_d};
    wire [SEF_NUM_EV-1:0] ev_old = {~spd_match_n_q, ~pos_done_n_q,
                                    servo_on_q};
    wire [SEF_NUM_EV-1:0] ev_set = ev_now & ~ev_old;
    wire [SEF_NUM_EV-1:0] clr    = wr_istat ?
                                   i_hwdata[SEF_NUM_EV-1:0] : '0;
    // Set wins over a clear in the same cycle
    wire [SEF_NUM_EV-1:0] stat_d = (irq_stat_q & ~clr) | ev_set;

    wire [31:0] status_w = {28'h000_0000, ~flag_n_q, ~spd_match_n_q,
                            ~pos_done_n_q, servo_on_q};
    wire [31:0] rd_mux =
        ~in_range                     ? 32'h0000_0000 :
        (rd_ofs == SEF_OFS_CTRL)      ? {26'h000_0000, mode_q, map_q} :
        (rd_ofs == SEF_OFS_POS_WIDTH) ? {24'h00_0000, pos_width_q} :
        (rd_ofs == SEF_OFS_SPD_WIDTH) ? {24'h00_0000, spd_width_q} :
        (rd_ofs == SEF_OFS_OUT_ALLOC) ? {16'h0000, alloc_q} :
        (rd_ofs == SEF_OFS_STATUS)    ? status_w :
        (rd_ofs == SEF_OFS_IRQ_STAT)  ? {29'h0000_0000, irq_stat_q} :
        (rd_ofs == SEF_OFS_IRQ_MASK)  ? {29'h0000_0000, irq_mask_q} :
                                        32'h0000_0000;

    // ********************************
    // Bus slave state
    // ********************************
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= wr_start & in_range;
            if (wr_start)
                wr_addr_q <= i_haddr[7:0];
            if (rd_start)
                rdata_q <= rd_mux;
        end
    end

    // ********************************
    // Settings
    // ********************************
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            map_q       <= SEF_MAP_GATED;
            mode_q      <= SEF_MODE_POSITION;
            pos_width_q <= SEF_POS_WIDTH_RST;
            spd_width_q <= SEF_SPD_WIDTH_RST;
            alloc_q     <= SEF_ALLOC_RST;
            irq_mask_q  <= '0;
        end
        else
        begin
            if (wr_ctrl && map_ok)
                map_q <= wmap;
            if (wr_ctrl && mode_ok)
                mode_q <= sef_mode_type'(wmode);
            if (wr_posw)
                pos_width_q <= posw_d;
            if (wr_spdw)
                spd_width_q <= spdw_d;
            if (wr_alloc)
                alloc_q <= i_hwdata[SEF_ALLOC_W-1:0];
            if (wr_imask)
                irq_mask_q <= i_hwdata[SEF_NUM_EV-1:0];
        end
    end

    // ********************************
    // Comparison sampling and outputs
    // ********************************
    // Fresh compare each update, no hysteresis or hold
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            pos_below_q <= 1'b0;
            spd_below_q <= 1'b0;
        end
        else if (i_loop_update)
        begin
            pos_below_q <= pos_below;
            spd_below_q <= spd_below;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            servo_on_q    <= 1'b0;
            pos_done_n_q  <= 1'b1;
            spd_match_n_q <= 1'b1;
            flag_n_q      <= 1'b1;
            irq_stat_q    <= '0;
        end
        else
        begin
            servo_on_q    <= servo_on_d;
            pos_done_n_q  <= ~pos_done_d;
            spd_match_n_q <= ~spd_match_d;
            flag_n_q      <= ~flag_d;
            irq_stat_q    <= stat_d;
        end
    end

    // ********************************
    // Output drive
    // ********************************
    // Servo off between host moves is the host's duty; no lockout here
    assign o_servo_on                  = servo_on_q;
    assign o_positioning_done_output_n = pos_done_n_q;
    assign o_speed_match_output_n      = spd_match_n_q;
    assign o_flag_terminal_n           = flag_n_q;
    assign o_irq                       = |(irq_stat_q & irq_mask_q);
    assign o_hrdata                    = rdata_q;
    assign o_hreadyout                 = 1'b1;
    assign o_hresp                     = 1'b0;
endmodule

// ==== src/sef_pkg.sv ====
// Package: register map, field layouts, reset values and modes of the
// servo enable and completion flag block.
// Assumes a 32-bit AHB-Lite register bus and one 200 MHz clock.
package sef_pkg;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] SEF_OFS_CTRL      = 8'h00;
    localparam logic [7:0] SEF_OFS_POS_WIDTH = 8'h04;
    localparam logic [7:0] SEF_OFS_SPD_WIDTH = 8'h08;
    localparam logic [7:0] SEF_OFS_OUT_ALLOC = 8'h0C;
    localparam logic [7:0] SEF_OFS_STATUS    = 8'h10;
    localparam logic [7:0] SEF_OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0] SEF_OFS_IRQ_MASK  = 8'h18;

    // ********************************
    // Field positions and widths
    // ********************************
    localparam int SEF_CTRL_MAP_LSB   = 0;
    localparam int SEF_CTRL_MAP_W     = 4;
    localparam int SEF_CTRL_MODE_LSB  = 4;
    localparam int SEF_CTRL_MODE_W    = 2;
    localparam int SEF_WIDTH_W        = 8;
    localparam int SEF_ALLOC_W        = 16;
    localparam int SEF_ERR_W          = 32;
    localparam int SEF_NUM_EV         = 3;
    localparam int SEF_ST_ENABLED     = 0;
    localparam int SEF_ST_POS_DONE    = 1;
    localparam int SEF_ST_SPD_MATCH   = 2;
    localparam int SEF_ST_FLAG_OUT    = 3;

    // ********************************
    // Reset values and limits
    // ********************************
    localparam logic [3:0]  SEF_MAP_GATED     = 4'h0;
    localparam logic [3:0]  SEF_MAP_ALWAYS_ON = 4'h7;
    localparam logic [7:0]  SEF_POS_WIDTH_RST = 8'h07;
    localparam logic [7:0]  SEF_POS_WIDTH_MAX = 8'hFA;
    localparam logic [7:0]  SEF_SPD_WIDTH_RST = 8'h0A;
    localparam logic [7:0]  SEF_SPD_WIDTH_MAX = 8'h64;
    localparam logic [15:0] SEF_ALLOC_RST     = 16'h3211;
    // Nibble of the allocation word that routes the shared flag
    localparam logic [3:0]  SEF_ALLOC_FLAG_ON = 4'h1;

    // ********************************
    // Control modes
    // ********************************
    typedef enum logic [1:0]
    {
        SEF_MODE_SPEED    = 2'b00,
        SEF_MODE_POSITION = 2'b01,
        SEF_MODE_TORQUE   = 2'b10
    } sef_mode_type;

    // Errors of one control update, carried together
    typedef struct packed
    {
        logic [SEF_ERR_W-1:0] pos_err;
        logic [SEF_ERR_W-1:0] spd_ref;
        logic [SEF_ERR_W-1:0] spd_act;
    } sef_loop_type;

endpackage

// ==== src/sef_sync.sv ====
// Three-stage synchroniser for a pin input with agreement filter.
// Assumes the pin is asynchronous to i_ref_clk.
`timescale 1ns/1ps
module sef_sync
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    // Pin and result
    input  wire logic i_pin,
    input  wire logic i_rst_val,
    output logic      o_level
);
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // ********************************
    // Capture chain
    // ********************************
    // Only s2 reads meta_q; the filter looks at stages two and three
    always_ff @(posedge i_ref_clk)
    begin
        meta_q <= i_pin;
        s2_q   <= meta_q;
        s3_q   <= s2_q;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            level_q <= i_rst_val;
        else if (s2_q == s3_q)
            level_q <= s3_q;
    end

    assign o_level = level_q;
endmodule

// ==== src/sef_cmp.sv ====
// Magnitude-below-width compare of one control loop error.
// Assumes signed two's complement operands from the control loop.
`timescale 1ns/1ps
module sef_cmp
    import sef_pkg::*;
(
    // Operands
    input  wire logic [SEF_ERR_W-1:0]   i_a,
    input  wire logic [SEF_ERR_W-1:0]   i_b,
    input  wire logic [SEF_WIDTH_W-1:0] i_width,
    // Result
    output logic                        o_below
);
    logic [SEF_ERR_W:0] diff;
    logic [SEF_ERR_W:0] mag;

    // Extra bit so the difference of extremes never wraps
    assign diff    = {i_a[SEF_ERR_W-1], i_a} - {i_b[SEF_ERR_W-1], i_b};
    assign mag     = diff[SEF_ERR_W] ? (~diff + 1'b1) : diff;
    assign o_below = mag < {{(SEF_ERR_W+1-SEF_WIDTH_W){1'b0}}, i_width};
endmodule

// ==== test/sef_host.sv ====
// Host model: drives the enable pin and the loop errors.
// Assumes calls are made just after a rising edge.
`timescale 1ns/1ps
module sef_host
    import sef_pkg::*;
(
    // Clock
    input  wire logic    i_ref_clk,
    // Pin and loop
    output logic         o_servo_enable_n,
    output logic         o_loop_update,
    output sef_loop_type o_loop
);
    initial
    begin
        o_servo_enable_n = 1'b1;
        o_loop_update    = 1'b0;
        o_loop           = '0;
    end
    // Enable moves only between motions, never to stop one
    task automatic set_enable(input logic en_n);
        o_servo_enable_n <= en_n;
    endtask
    // Motion goes through the errors; gap models a slow host
    task automatic push(input logic [31:0] pe, sr, sa, input int gap);
        repeat (gap) @(posedge i_ref_clk);
        o_loop        <= {pe, sr, sa};
        o_loop_update <= 1'b1;
        @(posedge i_ref_clk);
        // Stale errors scrambled so a late sample shows
        o_loop        <= ~{pe, sr, sa};
        o_loop_update <= 1'b0;
    endtask
endmodule

// ==== test/sef_chk.sv ====
// Checker of the enable and flag outputs at the sef_top ports.
// Assumes bind into sef_top; shadows follow taken word writes.
`timescale 1ns/1ps
module sef_chk
    import sef_pkg::*;
(
    // Clock, reset and bus
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // Pin, loop and flags
    input wire logic        i_servo_enable_n,
    input wire logic        i_loop_update,
    input wire logic        o_servo_on,
    input wire logic        o_positioning_done_output_n,
    input wire logic        o_speed_match_output_n,
    input wire logic        o_flag_terminal_n,
    input wire logic        o_irq
);
    // ****
    // Shadow of written fields
    // ****
    logic       wr_q;
    logic [7:0] wa_q;
    logic [2:0] wrs_q;
    logic [3:0] map_q;
    logic [1:0] mode_q;
    logic       alloc_q;
    wire logic  take_w = i_hsel & i_hready & i_htrans[1] & i_hwrite
                         & (i_haddr[31:8] == 24'h0);
    wire logic  ctl_w  = wr_q & (wa_q == SEF_OFS_CTRL);
    wire logic  alc_w  = wr_q & (wa_q == SEF_OFS_OUT_ALLOC);
    wire logic  map_ok = (i_hwdata[3:0] == SEF_MAP_GATED)
                         | (i_hwdata[3:0] == SEF_MAP_ALWAYS_ON);
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            wr_q    <= 1'b0;
            wa_q    <= 8'h0;
            wrs_q   <= 3'h0;
            map_q   <= SEF_MAP_GATED;
            mode_q  <= SEF_MODE_POSITION;
            alloc_q <= 1'b1;
        end
        else
        begin
            wr_q  <= take_w;
            wa_q  <= i_haddr[7:0];
            wrs_q <= {wrs_q[1:0], wr_q};
            if (ctl_w && map_ok)
                map_q <= i_hwdata[3:0];
            // Mode code 3 is refused by the block
            if (ctl_w && i_hwdata[5:4] != 2'b11)
                mode_q <= i_hwdata[5:4];
            if (alc_w)
                alloc_q <= (i_hwdata[3:0] == SEF_ALLOC_FLAG_ON);
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    AST_RST_IDLE: assert property ($fell(i_sys_rst) |-> !o_servo_on
        && o_positioning_done_output_n && o_speed_match_output_n
        && o_flag_terminal_n && !o_irq) else $error("not idle after reset");
    AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready and okay");
    AST_PIN_OFF: assert property (
        (map_q == SEF_MAP_GATED && i_servo_enable_n) [*6] |-> !o_servo_on)
        else $error("servo on with enable pin high");
    AST_MAP_ON: assert property (
        (map_q == SEF_MAP_ALWAYS_ON) [*3] |-> o_servo_on)
        else $error("servo off with forced enable");
    AST_DONE_CAUSE: assert property (
        $changed(o_positioning_done_output_n) |-> $past(i_loop_update, 2)
        || wr_q || wrs_q != 3'h0) else $error("done moved without cause");
    AST_SPD_IN_POS: assert property (
        (mode_q == SEF_MODE_POSITION) [*4] |-> o_speed_match_output_n)
        else $error("speed match asserted in position mode");
    AST_TORQUE_ON: assert property (
        (alloc_q && mode_q == SEF_MODE_TORQUE) [*4] |-> !o_flag_terminal_n)
        else $error("terminal released in torque mode");
    AST_ALLOC_OFF: assert property (
        (!alloc_q) [*4] |-> o_flag_terminal_n)
        else $error("terminal asserted while not routed");
    COV_DONE: cover property (!o_positioning_done_output_n);
    COV_MATCH: cover property (!o_speed_match_output_n);
    COV_IRQ: cover property (o_irq);
endmodule

bind sef_top sef_chk sef_chk_inst
(
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_servo_enable_n(i_servo_enable_n), .i_loop_update(i_loop_update),
    .o_servo_on(o_servo_on),
    .o_positioning_done_output_n(o_positioning_done_output_n),
    .o_speed_match_output_n(o_speed_match_output_n),
    .o_flag_terminal_n(o_flag_terminal_n), .o_irq(o_irq)
);

// ==== test/testbench.sv ====
// Testbench: register, pin gating, flag and interrupt scenarios.
// Assumes sef_top, the sef_host model and the bound checker.
`timescale 1ns/1ps
module testbench
    import sef_pkg::*;
;
    // ****
    // Signals
    // ****
    logic         i_ref_clk = 1'b0;
    logic         i_sys_rst = 1'b1;
    logic         i_hsel = 1'b0, i_hwrite = 1'b0;
    logic [1:0]   i_htrans = 2'b00;
    logic [31:0]  i_haddr = 32'h0, i_hwdata = 32'h0;
    logic [31:0]  o_hrdata, rv;
    logic         o_hreadyout, o_hresp, en_n, upd, o_servo_on, o_irq;
    logic         done_n, spd_n, term_n;
    sef_loop_type lp;
    int           n_fail = 0, num_checks = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    sef_host sef_host_inst
    (
        .i_ref_clk(i_ref_clk), .o_servo_enable_n(en_n),
        .o_loop_update(upd), .o_loop(lp)
    );
    sef_top sef_top_inst
    (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_servo_enable_n(en_n),
        .i_loop_update(upd), .i_loop(lp), .o_servo_on(o_servo_on),
        .o_positioning_done_output_n(done_n),
        .o_speed_match_output_n(spd_n), .o_flag_terminal_n(term_n),
        .o_irq(o_irq)
    );
    // ****
    // Tasks
    // ****
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge i_ref_clk);
            k++;
        end
        while (o_hreadyout !== 1'b1 && k < 50);
        if (o_hreadyout !== 1'b1)
        begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        i_hsel   <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr  <= {24'h0, a};
        i_hwrite <= w;
        wait_rdy();
        i_hsel   <= 1'b0;
        i_htrans <= 2'b00;
        i_hwdata <= d;
        wait_rdy();
        rv = o_hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    // Push errors, wait the two-edge answer plus margin, compare flags
    task automatic lpc(input logic [31:0] pe, sr, sa,
                       input logic [2:0] e, input int g);
        sef_host_inst.push(pe, sr, sa, g);
        cyc(3);
        chk({29'h0, done_n, spd_n, term_n}, {29'h0, e});
    endtask
    // ****
    // Scenarios
    // ****
    initial
    begin
        cyc(2);
        i_sys_rst <= 1'b0;
        cyc(1);
        rdc(SEF_OFS_CTRL, 32'h10);
        rdc(SEF_OFS_POS_WIDTH, 32'h7);
        rdc(SEF_OFS_SPD_WIDTH, 32'hA);
        rdc(SEF_OFS_OUT_ALLOC, 32'h3211);
        rdc(SEF_OFS_IRQ_MASK, 32'h0);
        rdc(8'h1C, 32'h0);
        cyc(6);
        chk({31'h0, o_servo_on}, 32'h0);
        sef_host_inst.set_enable(1'b0);
        cyc(6);
        chk({31'h0, o_servo_on}, 32'h1);
        rdc(SEF_OFS_STATUS, 32'h1);
        chk({31'h0, o_irq}, 32'h0);
        rdc(SEF_OFS_IRQ_STAT, 32'h1);
        wr(SEF_OFS_IRQ_MASK, 32'h1);
        cyc(2);
        chk({31'h0, o_irq}, 32'h1);
        wr(SEF_OFS_IRQ_STAT, 32'h1);
        cyc(2);
        chk({31'h0, o_irq}, 32'h0);
        sef_host_inst.set_enable(1'b1);
        wr(SEF_OFS_CTRL, 32'h17);
        cyc(6);
        chk({31'h0, o_servo_on}, 32'h1);
        wr(SEF_OFS_CTRL, 32'h13);
        rdc(SEF_OFS_CTRL, 32'h17);
        wr(SEF_OFS_CTRL, 32'h10);
        cyc(6);
        chk({31'h0, o_servo_on}, 32'h0);
        wr(SEF_OFS_POS_WIDTH, 32'hFF);
        rdc(SEF_OFS_POS_WIDTH, 32'hFA);
        wr(SEF_OFS_SPD_WIDTH, 32'hFF);
        rdc(SEF_OFS_SPD_WIDTH, 32'h64);
        wr(SEF_OFS_POS_WIDTH, 32'h7);
        lpc(32'h6, 32'h0, 32'h0, 3'b010, 0);
        lpc(32'h7, 32'h0, 32'h0, 3'b111, 5);
        lpc(32'hFFFF_FFFA, 32'h0, 32'h0, 3'b010, 0);
        wr(SEF_OFS_POS_WIDTH, 32'h0);
        lpc(32'h0, 32'h0, 32'h0, 3'b111, 0);
        wr(SEF_OFS_CTRL, 32'h0);
        lpc(32'h0, 32'h7D0, 32'h76C, 3'b111, 0);
        lpc(32'h0, 32'h7D0, 32'h76D, 3'b100, 0);
        lpc(32'h0, 32'h7D0, 32'h833, 3'b100, 2);
        lpc(32'h0, 32'h7D0, 32'h834, 3'b111, 0);
        wr(SEF_OFS_CTRL, 32'h20);
        // Mode code 3 names no mode, so torque must stay
        wr(SEF_OFS_CTRL, 32'h30);
        rdc(SEF_OFS_CTRL, 32'h20);
        cyc(4);
        chk({31'h0, term_n}, 32'h0);
        rdc(SEF_OFS_STATUS, 32'h8);
        wr(SEF_OFS_OUT_ALLOC, 32'h3210);
        cyc(4);
        chk({31'h0, term_n}, 32'h1);
        // Done and match rose since the clear; both still masked
        rdc(SEF_OFS_IRQ_STAT, 32'h6);
        chk({31'h0, o_irq}, 32'h0);
        end_of_test();
    end
endmodule
